// ---- common/cpu_bus_pkg.sv ----
// Shared types and constants for the CPU internal bus access block
package cpu_bus_pkg;

   // ----------------------------------------------------------------
   // Address map and bus timing
   // ----------------------------------------------------------------
   localparam logic [15:0] RAM_BASE = 16'hf780;
   localparam logic [15:0] TIMER_ADDR = 16'hffa0;
   localparam logic [15:0] PORT_DATA_ADDR = 16'hffd8;
   localparam logic [15:0] PORT_DIR_ADDR = 16'hffe8;
   localparam logic [1:0] MEM_STATES = 2'h2;
   localparam logic [1:0] PERIPH_SLOW_STATES = 2'h3;
   localparam logic [7:0] WRITE_ONLY_READ = 8'hff;
   localparam logic [15:0] EMPTY_READ = 16'hffff;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] PORT_DATA_RESET = 8'h00;
   localparam logic [7:0] PORT_DIR_RESET = 8'h00;
   localparam logic [15:0] TIMER_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_BIT, OP_MOVE} access_op_type;
   typedef enum logic [2:0] {BIT_SET, BIT_CLEAR, BIT_INVERT, BIT_STORE, BIT_INV_STORE} bit_op_type;
   typedef enum logic [1:0] {CPU_RESET, CPU_EXEC, CPU_HALT, CPU_EXCEPTION} cpu_state_type;
   typedef enum logic [1:0] {REGION_EMPTY, REGION_MEM, REGION_PERIPH} region_type;

   typedef struct packed {
      region_type region;
      logic wide;
      logic three_state;
   } region_attr_type;

   typedef struct packed {
      access_op_type op;
      logic word;
      logic [15:0] addr;
      logic [15:0] wdata;
      bit_op_type bit_op;
      logic [2:0] bit_num;
      logic carry;
      logic [15:0] move_source_ptr;
      logic [15:0] move_dest_ptr;
      logic [7:0] move_count_reg;
   } cpu_req_type;

   typedef struct packed {
      logic [15:0] rdata;
      logic [15:0] move_source_ptr;
      logic [15:0] move_dest_ptr;
   } cpu_resp_type;

endpackage

// ---- src/cpu_bus_access.sv ----
// CPU internal bus sequencer with on-chip RAM, port and reload timer registers
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_access
   import cpu_bus_pkg::*;
#(
   parameter int RAM_WORDS = 1024
)(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic req_valid,
   input wire cpu_req_type req,
   input wire logic sleep_req,
   input wire logic exc_req,
   input wire logic exc_done,
   input wire logic [7:0] port_pin_in,
   output logic req_ready,
   output logic resp_valid,
   output cpu_resp_type resp,
   output cpu_state_type cpu_state,
   output logic [1:0] bus_state,
   output logic [7:0] port_pin_out,
   output logic [7:0] port_pin_oe
);

   localparam int IDX_W = $clog2(RAM_WORDS);
   localparam logic [16:0] RAM_BYTES = 17'(RAM_WORDS * 2);

   typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_type;
   typedef enum logic [2:0] {STEP_SINGLE, STEP_SPLIT_HI, STEP_SPLIT_LO, STEP_RMW_RD, STEP_RMW_WR,
      STEP_MV_RD, STEP_MV_WR} step_type;

   function automatic region_attr_type decode(input logic [15:0] a);
      region_attr_type r;
      r = '{REGION_EMPTY, 1'b0, 1'b0};
      if (a >= RAM_BASE && {1'b0, 16'(a - RAM_BASE)} < RAM_BYTES)
         r.region = REGION_MEM;
      else if (a == TIMER_ADDR)
         r = '{REGION_PERIPH, 1'b1, 1'b1};
      else if (a == PORT_DATA_ADDR)
         r = '{REGION_PERIPH, 1'b0, 1'b0};
      else if (a == PORT_DIR_ADDR)
         r = '{REGION_PERIPH, 1'b0, 1'b1};
      return r;
   endfunction

   function automatic logic [7:0] bit_modify(input logic [7:0] b, input bit_op_type op,
                                             input logic [2:0] n, input logic c);
      logic [7:0] m;
      m = 8'h01 << n;
      unique case (op)
         BIT_SET: return b | m;
         BIT_CLEAR: return b & ~m;
         BIT_INVERT: return b ^ m;
         BIT_STORE: return c ? (b | m) : (b & ~m);
         BIT_INV_STORE: return c ? (b & ~m) : (b | m);
         default: return b;
      endcase
   endfunction

   seq_type state_q, state_d;
   step_type step_q, step_d;
   logic [1:0] tcount_q, tcount_d;
   logic [15:0] cyc_addr_q, cyc_addr_d, cyc_wdata_q, cyc_wdata_d, rdata_q, rdata_d;
   logic cyc_wr_q, cyc_wr_d, cyc_word_q, cyc_word_d;
   cpu_req_type req_q, req_d;
   logic [7:0] move_cnt_q, move_cnt_d;
   logic [15:0] src_q, src_d, dst_q, dst_d;
   logic resp_valid_q, resp_valid_d, req_ready_q, req_ready_d;
   cpu_resp_type resp_q, resp_d;
   cpu_state_type cpu_state_q, cpu_state_d;
   logic [7:0] port_data_q, port_data_d, port_dir_q, port_dir_d;
   logic [15:0] reload_q, reload_d, counter_q, counter_d;
   logic [15:0] mem_q [RAM_WORDS];
   region_attr_type attr, req_attr;
   logic [1:0] last_state;
   logic last_fire, wr_fire, mem_we_hi, mem_we_lo;
   logic [15:0] mem_off, rd_word;
   logic [7:0] rd_byte;
   logic [IDX_W-1:0] idx;

   // ----------------------------------------------------------------
   // Cycle decode and read data
   // ----------------------------------------------------------------
   assign attr = decode(cyc_addr_q);
   assign req_attr = decode(req.addr);
   assign last_state = attr.three_state ? PERIPH_SLOW_STATES : MEM_STATES;
   assign last_fire = state_q == SEQ_RUN && tcount_q == last_state;
   assign wr_fire = last_fire && cyc_wr_q;
   assign mem_off = 16'(cyc_addr_q - RAM_BASE);
   assign idx = mem_off[IDX_W:1];

   always_comb
   begin
      rd_word = EMPTY_READ;
      rd_byte = EMPTY_READ[7:0];
      if (attr.region == REGION_MEM)
      begin
         rd_word = mem_q[idx];
         rd_byte = cyc_addr_q[0] ? mem_q[idx][7:0] : mem_q[idx][15:8];
      end
      else if (attr.region == REGION_PERIPH)
      begin
         if (cyc_addr_q == TIMER_ADDR)
            rd_word = counter_q;
         if (cyc_addr_q == PORT_DATA_ADDR)
            rd_byte = (port_dir_q & port_data_q) | (~port_dir_q & port_pin_in);
         else
            rd_byte = WRITE_ONLY_READ;
      end
   end

   // ----------------------------------------------------------------
   // Bus cycle sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      step_d = step_q;
      tcount_d = tcount_q;
      cyc_addr_d = cyc_addr_q;
      cyc_wr_d = cyc_wr_q;
      cyc_word_d = cyc_word_q;
      cyc_wdata_d = cyc_wdata_q;
      req_d = req_q;
      rdata_d = rdata_q;
      move_cnt_d = move_cnt_q;
      src_d = src_q;
      dst_d = dst_q;
      resp_valid_d = 1'b0;
      resp_d = resp_q;
      unique case (state_q)
         SEQ_IDLE:
            if (req_valid && req_ready_q)
            begin
               req_d = req;
               state_d = SEQ_RUN;
               tcount_d = 2'h1;
               cyc_addr_d = req.addr;
               cyc_wdata_d = req.wdata;
               cyc_wr_d = req.op == OP_WRITE;
               cyc_word_d = req.word;
               step_d = STEP_SINGLE;
               unique case (req.op)
                  OP_READ, OP_WRITE:
                     if (req.word && req_attr.region == REGION_PERIPH && !req_attr.wide)
                     begin
                        step_d = STEP_SPLIT_HI;
                        cyc_word_d = 1'b0;
                        cyc_wdata_d = {8'h00, req.wdata[15:8]};
                     end
                  OP_BIT:
                  begin
                     step_d = STEP_RMW_RD;
                     cyc_word_d = 1'b0;
                  end
                  OP_MOVE:
                  begin
                     step_d = STEP_MV_RD;
                     cyc_word_d = 1'b0;
                     cyc_addr_d = req.move_source_ptr;
                     src_d = req.move_source_ptr;
                     dst_d = req.move_dest_ptr;
                     move_cnt_d = req.move_count_reg;
                     if (req.move_count_reg == 8'h00)
                     begin
                        state_d = SEQ_IDLE;
                        tcount_d = 2'h0;
                        resp_valid_d = 1'b1;
                        resp_d = '{rdata_q, req.move_source_ptr, req.move_dest_ptr};
                     end
                  end
               endcase
            end
         SEQ_RUN:
            if (!last_fire)
               tcount_d = tcount_q + 2'h1;
            else
            begin
               tcount_d = 2'h1;
               unique case (step_q)
                  STEP_SINGLE:
                     rdata_d = cyc_word_q ? rd_word : {8'h00, rd_byte};
                  STEP_SPLIT_HI:
                  begin
                     rdata_d = {rd_byte, 8'h00};
                     step_d = STEP_SPLIT_LO;
                     cyc_addr_d = cyc_addr_q + 16'h0001;
                     cyc_wdata_d = {8'h00, req_q.wdata[7:0]};
                  end
                  STEP_SPLIT_LO:
                     rdata_d = {rdata_q[15:8], rd_byte};
                  STEP_RMW_RD:
                  begin
                     step_d = STEP_RMW_WR;
                     cyc_wr_d = 1'b1;
                     cyc_wdata_d = {8'h00, bit_modify(rd_byte, req_q.bit_op, req_q.bit_num, req_q.carry)};
                  end
                  STEP_RMW_WR:
                     rdata_d = cyc_wdata_q;
                  STEP_MV_RD:
                  begin
                     step_d = STEP_MV_WR;
                     cyc_wr_d = 1'b1;
                     cyc_addr_d = dst_q;
                     cyc_wdata_d = {8'h00, rd_byte};
                     rdata_d = {8'h00, rd_byte};
                  end
                  STEP_MV_WR:
                  begin
                     // Destination is trusted not to pass the top of the space
                     src_d = src_q + 16'h0001;
                     dst_d = dst_q + 16'h0001;
                     move_cnt_d = move_cnt_q - 8'h01;
                     step_d = STEP_MV_RD;
                     cyc_wr_d = 1'b0;
                     cyc_addr_d = src_q + 16'h0001;
                  end
               endcase
               if (step_q == STEP_SINGLE || step_q == STEP_SPLIT_LO || step_q == STEP_RMW_WR
                   || (step_q == STEP_MV_WR && move_cnt_q == 8'h01))
               begin
                  state_d = SEQ_IDLE;
                  tcount_d = 2'h0;
                  resp_valid_d = 1'b1;
                  resp_d = '{rdata_d, src_d, dst_d};
               end
            end
      endcase
   end

   // Accepts only while idle in execution or exception handling
   assign req_ready_d = state_d == SEQ_IDLE && (cpu_state_d == CPU_EXEC || cpu_state_d == CPU_EXCEPTION);

   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         state_q <= SEQ_IDLE;
         step_q <= STEP_SINGLE;
         tcount_q <= 2'h0;
         cyc_addr_q <= 16'h0000;
         cyc_wr_q <= 1'b0;
         cyc_word_q <= 1'b0;
         cyc_wdata_q <= 16'h0000;
         req_q <= '0;
         rdata_q <= 16'h0000;
         move_cnt_q <= 8'h00;
         src_q <= 16'h0000;
         dst_q <= 16'h0000;
         resp_valid_q <= 1'b0;
         resp_q <= '0;
         req_ready_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         step_q <= step_d;
         tcount_q <= tcount_d;
         cyc_addr_q <= cyc_addr_d;
         cyc_wr_q <= cyc_wr_d;
         cyc_word_q <= cyc_word_d;
         cyc_wdata_q <= cyc_wdata_d;
         req_q <= req_d;
         rdata_q <= rdata_d;
         move_cnt_q <= move_cnt_d;
         src_q <= src_d;
         dst_q <= dst_d;
         resp_valid_q <= resp_valid_d;
         resp_q <= resp_d;
         req_ready_q <= req_ready_d;
      end

   // ----------------------------------------------------------------
   // CPU top-level state
   // ----------------------------------------------------------------
   always_comb
   begin
      cpu_state_d = cpu_state_q;
      unique case (cpu_state_q)
         CPU_RESET: cpu_state_d = CPU_EXCEPTION;
         CPU_EXCEPTION: if (exc_done) cpu_state_d = CPU_EXEC;
         CPU_EXEC:
            if (exc_req)
               cpu_state_d = CPU_EXCEPTION;
            else if (sleep_req && state_d == SEQ_IDLE)
               cpu_state_d = CPU_HALT;
         CPU_HALT: if (exc_req) cpu_state_d = CPU_EXCEPTION;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         cpu_state_q <= CPU_RESET;
      else
         cpu_state_q <= cpu_state_d;

   // ----------------------------------------------------------------
   // Peripheral registers and on-chip RAM
   // ----------------------------------------------------------------
   always_comb
   begin
      port_data_d = port_data_q;
      port_dir_d = port_dir_q;
      reload_d = reload_q;
      counter_d = (counter_q == 16'hffff) ? reload_q : counter_q + 16'h0001;
      mem_we_hi = 1'b0;
      mem_we_lo = 1'b0;
      if (wr_fire && attr.region == REGION_MEM)
      begin
         mem_we_hi = cyc_word_q || !cyc_addr_q[0];
         mem_we_lo = cyc_word_q || cyc_addr_q[0];
      end
      if (wr_fire && attr.region == REGION_PERIPH)
      begin
         if (cyc_addr_q == TIMER_ADDR && cyc_word_q)
            reload_d = cyc_wdata_q;
         if (cyc_addr_q == PORT_DATA_ADDR)
            port_data_d = cyc_wdata_q[7:0];
         if (cyc_addr_q == PORT_DIR_ADDR)
            port_dir_d = cyc_wdata_q[7:0];
      end
   end

   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         port_data_q <= PORT_DATA_RESET;
         port_dir_q <= PORT_DIR_RESET;
         reload_q <= TIMER_RESET;
         counter_q <= TIMER_RESET;
      end
      else
      begin
         port_data_q <= port_data_d;
         port_dir_q <= port_dir_d;
         reload_q <= reload_d;
         counter_q <= counter_d;
      end

   always_ff @(posedge clk)
   begin
      if (mem_we_hi)
         mem_q[idx][15:8] <= cyc_word_q ? cyc_wdata_q[15:8] : cyc_wdata_q[7:0];
      if (mem_we_lo)
         mem_q[idx][7:0] <= cyc_wdata_q[7:0];
   end

   assign req_ready = req_ready_q;
   assign resp_valid = resp_valid_q;
   assign resp = resp_q;
   assign cpu_state = cpu_state_q;
   assign bus_state = tcount_q;
   assign port_pin_out = port_data_q;
   assign port_pin_oe = port_dir_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_cycle_length:
      assert property (tcount_q == 2'h1 |=> tcount_q == 2'h2 ##1 tcount_q != 2'h2)
      else $error("bus cycle not two or three states");
   a_mem_two_states:
      assert property (tcount_q == 2'h1 && !attr.three_state |=> tcount_q == 2'h2 ##1 tcount_q inside {2'h0, 2'h1})
      else $error("fast cycle longer than two states");
   a_slow_three_states:
      assert property (tcount_q == 2'h1 && attr.three_state |=> tcount_q == 2'h2 ##1 tcount_q == 2'h3)
      else $error("slow peripheral cycle not three states");
   a_split_second_half:
      assert property ($rose(step_q == STEP_SPLIT_LO) |-> cyc_addr_q == $past(cyc_addr_q) + 16'h0001)
      else $error("split word second cycle at wrong address");
   a_rmw_back_to_back:
      assert property (last_fire && step_q == STEP_RMW_RD
         |=> tcount_q == 2'h1 && cyc_wr_q && step_q == STEP_RMW_WR && $stable(cyc_addr_q))
      else $error("bit write-back not immediate to same address");
   a_wide_byte_ignored:
      assert property (wr_fire && cyc_addr_q == TIMER_ADDR && !cyc_word_q |=> $stable(reload_q))
      else $error("byte write reached wide register");
   a_reload_write:
      assert property (wr_fire && cyc_addr_q == TIMER_ADDR && cyc_word_q |=> reload_q == $past(cyc_wdata_q))
      else $error("reload value not written");
   a_write_only_read:
      assert property (last_fire && !cyc_wr_q && step_q == STEP_SINGLE && cyc_addr_q == PORT_DIR_ADDR
         |=> resp_valid_q && resp_q.rdata == 16'h00ff)
      else $error("write-only register did not read all ones");
   a_port_read_mix:
      assert property (last_fire && !cyc_wr_q && step_q == STEP_SINGLE && cyc_addr_q == PORT_DATA_ADDR
         |=> resp_q.rdata[7:0] == ($past(port_dir_q & port_data_q) | $past(~port_dir_q & port_pin_in)))
      else $error("port read mixes pins and latch wrongly");
   a_reset_exception:
      assert property (cpu_state_q == CPU_RESET |=> cpu_state_q == CPU_EXCEPTION ##1 cpu_state_q != CPU_RESET)
      else $error("reset not followed by exception handling");
   a_move_finish:
      assert property (last_fire && step_q == STEP_MV_WR && move_cnt_q == 8'h01 |=> resp_valid_q && state_q == SEQ_IDLE)
      else $error("block move did not end after last byte");

   c_split_word: cover property (step_q == STEP_SPLIT_HI ##[2:3] step_q == STEP_SPLIT_LO ##[2:3] resp_valid_q);
   c_bit_rmw: cover property (step_q == STEP_RMW_RD ##[2:3] step_q == STEP_RMW_WR ##[2:3] resp_valid_q);
   c_move_two: cover property (step_q == STEP_MV_WR ##[2:3] step_q == STEP_MV_RD ##[4:6] resp_valid_q);
   c_halt_wake: cover property (cpu_state_q == CPU_HALT ##[1:20] cpu_state_q == CPU_EXCEPTION);

endmodule // cpu_bus_access
`default_nettype wire

// ---- tb/port_pins_model.sv ----
// Pin-side model of the port: external drivers meet the port's output drivers
`timescale 1ns/1ps
`default_nettype none
module port_pins_model
(
   input wire logic [7:0] port_pin_out,
   input wire logic [7:0] port_pin_oe,
   input wire logic [7:0] ext_level,
   output logic [7:0] port_pin_in
);
   // Driven bits show the latch, undriven bits the outside level
   assign port_pin_in = (port_pin_oe & port_pin_out) | (~port_pin_oe & ext_level);
endmodule // port_pins_model
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking testbench for the CPU internal bus access block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import cpu_bus_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic req_valid = 1'b0;
   cpu_req_type req = '0;
   cpu_req_type r = '0;
   logic sleep_req = 1'b0;
   logic exc_req = 1'b0;
   logic exc_done = 1'b0;
   logic [7:0] ext_level = 8'h40;
   logic [7:0] port_pin_in;
   logic req_ready, resp_valid;
   cpu_resp_type resp;
   cpu_state_type cpu_state;
   logic [1:0] bus_state;
   logic [7:0] port_pin_out, port_pin_oe;
   int num_errors = 0;
   int checked = 0;
   logic [15:0] rd, rd2;
   int i;
   bit_op_type bop [5] = '{BIT_SET, BIT_CLEAR, BIT_INVERT, BIT_STORE, BIT_INV_STORE};
   logic [2:0] bnum [5] = '{3'h0, 3'h1, 3'h7, 3'h2, 3'h0};
   logic [7:0] bexp [5] = '{8'h5b, 8'h59, 8'hd9, 8'hdd, 8'hdc};

   always #25 clk = ~clk;

   cpu_bus_access #(.RAM_WORDS(64)) cpu_bus_access_i (.clk(clk), .rst_b(rst_b), .req_valid(req_valid),
      .req(req), .sleep_req(sleep_req), .exc_req(exc_req), .exc_done(exc_done), .port_pin_in(port_pin_in),
      .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp), .cpu_state(cpu_state),
      .bus_state(bus_state), .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe));
   port_pins_model port_pins_model_i (.port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
      .ext_level(ext_level), .port_pin_in(port_pin_in));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task give_verdict;
      if (num_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Runs one request; lat_e 0 skips the timing checks
   task automatic do_req(input access_op_type op, input logic wd, input logic [15:0] a,
      input logic [15:0] wdat, input int lat_e, input logic [1:0] pk_e, output logic [15:0] rdat);
      int n;
      int lat;
      logic [1:0] pk;
      n = 0;
      lat = 0;
      pk = 2'h0;
      r.op = op;
      r.word = wd;
      r.addr = a;
      r.wdata = wdat;
      @(negedge clk);
      req = r;
      req_valid = 1'b1;
      while (req_ready !== 1'b1 && n < 40)
      begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      do
      begin
         @(negedge clk);
         req_valid = 1'b0;
         lat++;
         if (bus_state > pk)
            pk = bus_state;
      end
      while (resp_valid !== 1'b1 && lat < 60);
      if (resp_valid !== 1'b1)
      begin
         num_errors++;
         $display("BAD %0t no response", $time);
      end
      rdat = resp.rdata;
      if (lat_e != 0)
      begin
         chk(16'(lat), 16'(lat_e), "latency");
         chk({14'h0, pk}, {14'h0, pk_e}, "state count");
      end
   endtask

   initial
   begin
      #(50 * 4000);
      num_errors++;
      give_verdict();
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic cpu_states;
      @(negedge clk);
      chk({14'h0, cpu_state}, {14'h0, CPU_RESET}, "reset state");
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      chk({14'h0, cpu_state}, {14'h0, CPU_EXCEPTION}, "exception after reset");
      exc_done = 1'b1;
      @(negedge clk);
      exc_done = 1'b0;
      chk({14'h0, cpu_state}, {14'h0, CPU_EXEC}, "execution");
      sleep_req = 1'b1;
      @(negedge clk);
      sleep_req = 1'b0;
      @(negedge clk);
      chk({14'h0, cpu_state}, {14'h0, CPU_HALT}, "halt");
      chk({15'h0, req_ready}, 16'h0, "ready in halt");
      exc_req = 1'b1;
      @(negedge clk);
      exc_req = 1'b0;
      chk({14'h0, cpu_state}, {14'h0, CPU_EXCEPTION}, "wake to exception");
      exc_done = 1'b1;
      @(negedge clk);
      exc_done = 1'b0;
      chk({14'h0, cpu_state}, {14'h0, CPU_EXEC}, "back to execution");
   endtask

   task automatic ram_sizes;
      do_req(OP_WRITE, 1'b1, RAM_BASE, 16'h1234, 3, 2'h2, rd);
      do_req(OP_READ, 1'b1, RAM_BASE, 16'h0, 3, 2'h2, rd);
      chk(rd, 16'h1234, "ram word");
      do_req(OP_READ, 1'b0, RAM_BASE, 16'h0, 3, 2'h2, rd);
      chk(rd, 16'h0012, "ram high byte");
      do_req(OP_READ, 1'b0, RAM_BASE + 16'h1, 16'h0, 3, 2'h2, rd);
      chk(rd, 16'h0034, "ram low byte");
   endtask

   task automatic port_bits;
      do_req(OP_WRITE, 1'b0, PORT_DIR_ADDR, 16'h003f, 4, 2'h3, rd);
      chk({8'h0, port_pin_oe}, 16'h003f, "direction");
      do_req(OP_READ, 1'b0, PORT_DIR_ADDR, 16'h0, 4, 2'h3, rd);
      chk(rd, {8'h0, WRITE_ONLY_READ}, "write-only read");
      do_req(OP_WRITE, 1'b0, PORT_DATA_ADDR, 16'h0080, 3, 2'h2, rd);
      do_req(OP_READ, 1'b0, PORT_DATA_ADDR, 16'h0, 3, 2'h2, rd);
      chk(rd, 16'h0040, "port read mix");
      r.bit_op = BIT_SET;
      r.bit_num = 3'h0;
      do_req(OP_BIT, 1'b0, PORT_DATA_ADDR, 16'h0, 5, 2'h2, rd);
      chk({8'h0, port_pin_out}, 16'h0041, "bit set on port");
      r.bit_op = BIT_CLEAR;
      do_req(OP_BIT, 1'b0, PORT_DIR_ADDR, 16'h0, 7, 2'h3, rd);
      chk({8'h0, port_pin_oe}, 16'h00fe, "bit clear on write-only");
      do_req(OP_WRITE, 1'b1, PORT_DATA_ADDR, 16'h9966, 5, 2'h2, rd);
      chk({8'h0, port_pin_out}, 16'h0099, "split high byte");
      do_req(OP_WRITE, 1'b0, RAM_BASE + 16'h6, 16'h0080, 3, 2'h2, rd);
      r.bit_op = BIT_SET;
      do_req(OP_BIT, 1'b0, RAM_BASE + 16'h6, 16'h0, 5, 2'h2, rd);
      do_req(OP_READ, 1'b0, RAM_BASE + 16'h6, 16'h0, 3, 2'h2, rd);
      chk(rd, 16'h0081, "port copy in ram");
      do_req(OP_WRITE, 1'b0, PORT_DATA_ADDR, rd, 3, 2'h2, rd);
      chk({8'h0, port_pin_out}, 16'h0081, "port from copy");
   endtask

   task automatic ram_bits;
      do_req(OP_WRITE, 1'b0, RAM_BASE + 16'h4, 16'h005a, 3, 2'h2, rd);
      for (i = 0; i < 5; i++)
      begin
         r.bit_op = bop[i];
         r.bit_num = bnum[i];
         r.carry = 1'b1;
         do_req(OP_BIT, 1'b0, RAM_BASE + 16'h4, 16'h0, 5, 2'h2, rd);
         do_req(OP_READ, 1'b0, RAM_BASE + 16'h4, 16'h0, 3, 2'h2, rd);
         chk(rd, {8'h0, bexp[i]}, "ram bit op");
      end
   endtask

   task automatic timer_and_empty;
      do_req(OP_READ, 1'b0, TIMER_ADDR, 16'h0, 4, 2'h3, rd);
      chk(rd, 16'h00ff, "timer byte read");
      do_req(OP_WRITE, 1'b0, TIMER_ADDR, 16'h0055, 4, 2'h3, rd);
      do_req(OP_WRITE, 1'b1, TIMER_ADDR, 16'hfff0, 4, 2'h3, rd);
      do_req(OP_READ, 1'b1, TIMER_ADDR, 16'h0, 4, 2'h3, rd);
      do_req(OP_READ, 1'b1, TIMER_ADDR, 16'h0, 4, 2'h3, rd2);
      checked++;
      if (rd === rd2)
      begin
         num_errors++;
         $display("BAD %0t counter not running", $time);
      end
      do_req(OP_WRITE, 1'b1, 16'h0100, 16'habcd, 3, 2'h2, rd);
      do_req(OP_READ, 1'b1, 16'h0100, 16'h0, 3, 2'h2, rd);
      chk(rd, EMPTY_READ, "empty read");
   endtask

   task automatic block_move;
      r.move_source_ptr = RAM_BASE;
      r.move_dest_ptr = RAM_BASE + 16'h10;
      r.move_count_reg = 8'h02;
      do_req(OP_MOVE, 1'b0, 16'h0, 16'h0, 9, 2'h2, rd);
      chk(resp.move_source_ptr, RAM_BASE + 16'h2, "move source end");
      chk(resp.move_dest_ptr, RAM_BASE + 16'h12, "move dest end");
      do_req(OP_READ, 1'b1, RAM_BASE + 16'h10, 16'h0, 3, 2'h2, rd);
      chk(rd, 16'h1234, "moved data");
      r.move_count_reg = 8'h00;
      do_req(OP_MOVE, 1'b0, 16'h0, 16'h0, 1, 2'h0, rd);
      chk(resp.move_dest_ptr, RAM_BASE + 16'h10, "empty move");
   endtask

   initial
   begin
      cpu_states();
      ram_sizes();
      port_bits();
      ram_bits();
      timer_and_empty();
      block_move();
      give_verdict();
   end
endmodule // tb
`default_nettype wire
